// *** src/toc_pkg.sv ***
// Shared constants and types of the two-channel timer output-compare block.
// Assumes a 32-bit APB slave port and an external 8-bit counter.
package toc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFF_CTRL   = 8'h00;
    localparam logic [7:0]  OFF_CMP_A  = 8'h04;
    localparam logic [7:0]  OFF_CMP_B  = 8'h08;
    localparam logic [7:0]  OFF_FLAGS  = 8'h0C;
    localparam logic [7:0]  OFF_FORCE  = 8'h10;
    localparam logic [7:0]  OFF_STATUS = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_ACT_A_LSB = 0;
    localparam int CTRL_ACT_B_LSB = 2;
    localparam int CTRL_MODE_LSB  = 4;
    localparam int CTRL_IEN_LSB   = 8;
    localparam int STAT_OUT_LSB   = 0;
    localparam int STAT_CMP_A_LSB = 8;
    localparam int STAT_CMP_B_LSB = 16;

    // ------------------------------------------------------------------
    // Values, reset values and action codes
    // ------------------------------------------------------------------
    localparam int          NCH        = 2;
    localparam logic [7:0]  CNT_MAX    = 8'hFF;
    localparam logic [7:0]  CNT_BOTTOM = 8'h00;
    localparam logic [7:0]  CMP_RST    = 8'h00;
    localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
    localparam logic [1:0]  ACT_NONE   = 2'h0;
    localparam logic [1:0]  ACT_TOGGLE = 2'h1;
    localparam logic [1:0]  ACT_CLEAR  = 2'h2;
    localparam logic [1:0]  ACT_SET    = 2'h3;

    // Mode select: bit 0 marks PWM, bit 1 marks single slope among PWM
    typedef logic [2:0] toc_mode_t;
    localparam toc_mode_t MODE_NORMAL = 3'h0;

    // Control register contents
    typedef struct packed {
        logic [1:0] int_en;
        toc_mode_t  mode;
        logic [1:0] act_b;
        logic [1:0] act_a;
    } toc_ctrl_s;

    localparam toc_ctrl_s CTRL_RST = '{int_en: 2'h0, mode: MODE_NORMAL,
                                       act_b: ACT_NONE, act_a: ACT_NONE};

    // Counter-side indications, all in the system clock domain
    typedef struct packed {
        logic [7:0] count;
        logic       down;
        logic       at_top;
        logic       at_bottom;
        logic       tick;
        logic       count_write;
    } toc_cnt_s;

endpackage

// *** src/toc_compare.sv ***
// Output-compare unit: two channels, flags, waveform outputs, pin override.
// Assumes the counter, prescaler and tick generation sit outside and
// deliver toc_cnt_s synchronous to clk_sys.
//
// Summary of operation
// (R1) Compare count against both compare values continuously
// (R2) Match flag sets at the following timer tick
// (R3) Enabled flag requests interrupt, cleared on service
// (R4) Writing one clears a flag, zero ignored
// (R5) Output from match, mode, action, top/bottom
// (R6) Double buffering only in PWM modes
// (R7) Buffer moves to active at top/bottom
// (R8) CPU reaches buffer or active per mode
// (R9) Force strobe forces a match outside PWM
// (R10) Forced match: no flag, output updates normally
// (R11) Counter write blocks matches for next tick
// (R12) Output state kept across mode changes
// (R13) Action bits unbuffered, used at next match
// (R14) Force after action change applies it now
// (R15) Nonzero action overrides general port value
// (R16) Pin direction stays with port direction bit
// (R17) Action zero leaves output state unchanged
// (R18) Timer tick is a clock enable
// (R19) Software sets output state before enabling pin
// (R20) Software avoids writing count equal to compare
// (R21) Non-PWM actions: none, toggle, clear, set
// (R22) PWM actions: two non-inverted, three inverted
// (R23) Phase correct: clear up, set down
// (R24) Force ignored in PWM, strobe reads zero
`timescale 1ns/10ps

module toc_compare (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst,
    // APB slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [toc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Counter indications
    input  wire toc_pkg::toc_cnt_s           cnt,
    // Interrupt request and service
    output logic      [toc_pkg::NCH-1:0]     irq_req,
    input  wire logic [toc_pkg::NCH-1:0]     irq_ack,
    // Port pin logic
    input  wire logic [toc_pkg::NCH-1:0]     port_out_value,
    input  wire logic [toc_pkg::NCH-1:0]     output_pin_direction_bit,
    output logic      [toc_pkg::NCH-1:0]     pin_out,
    output logic      [toc_pkg::NCH-1:0]     pin_oe_n,
    output logic      [toc_pkg::NCH-1:0]     channel_output_state
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    toc_pkg::toc_ctrl_s ctrl_q;
    logic [7:0]         cmp_act_q [toc_pkg::NCH];
    logic [7:0]         cmp_buf_q [toc_pkg::NCH];
    logic [1:0]         act       [toc_pkg::NCH];
    logic [toc_pkg::NCH-1:0] match_flag_q;
    logic [toc_pkg::NCH-1:0] out_q;
    logic [toc_pkg::NCH-1:0] match;
    logic [toc_pkg::NCH-1:0] hit;
    logic [toc_pkg::NCH-1:0] force_ev;
    logic [toc_pkg::NCH-1:0] connected;
    logic               block_q;
    logic               pwm;
    logic               fast;
    logic               acc;
    logic               wr;
    logic               addr_ok;
    logic               reload;
    logic [31:0]        rd_d;

    // ------------------------------------------------------------------
    // Mode decoding and bus qualifiers
    // ------------------------------------------------------------------

    // Odd mode codes are the PWM ones
    assign pwm  = ctrl_q.mode[0];
    assign fast = ctrl_q.mode[0] & ctrl_q.mode[1];
    assign acc  = psel & penable;
    assign wr   = acc & pwrite;

    // Actions are read straight from control, never buffered
    assign act[0] = ctrl_q.act_a; // R13
    assign act[1] = ctrl_q.act_b; // R13

    // Legal offsets; anything else answers with an error
    always_comb begin
        case (paddr)
            toc_pkg::OFF_CTRL,
            toc_pkg::OFF_CMP_A,
            toc_pkg::OFF_CMP_B,
            toc_pkg::OFF_FLAGS,
            toc_pkg::OFF_FORCE,
            toc_pkg::OFF_STATUS: addr_ok = 1'b1;
            default:             addr_ok = 1'b0;
        endcase
    end

    // Zero wait states: the answer comes in the access cycle
    assign pready  = acc;
    assign pslverr = acc & ~addr_ok;

    // ------------------------------------------------------------------
    // Comparators and match qualification
    // ------------------------------------------------------------------

    // Per-channel equality, gated by tick and counter-write block
    always_comb begin
        for (int ch = 0; ch < toc_pkg::NCH; ch++) begin
            match[ch]    = (cnt.count == cmp_act_q[ch]); // R1
            hit[ch]      = cnt.tick & match[ch] & ~block_q; // R18
            force_ev[ch] = wr & (paddr == toc_pkg::OFF_FORCE)
                           & pwdata[ch] & ~pwm; // R9 R24
        end
    end

    // Counter write blanks the comparator for one timer cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            block_q <= 1'b0;
        end else if (cnt.count_write) begin
            block_q <= 1'b1; // R11
        end else if (cnt.tick) begin
            block_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------

    // Mode change does not touch output state
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_q <= toc_pkg::CTRL_RST;
        end else if (wr && paddr == toc_pkg::OFF_CTRL) begin
            ctrl_q.act_a  <= pwdata[toc_pkg::CTRL_ACT_A_LSB +: 2];
            ctrl_q.act_b  <= pwdata[toc_pkg::CTRL_ACT_B_LSB +: 2];
            ctrl_q.mode   <= pwdata[toc_pkg::CTRL_MODE_LSB +: 3];
            ctrl_q.int_en <= pwdata[toc_pkg::CTRL_IEN_LSB +: 2];
        end
    end

    // ------------------------------------------------------------------
    // Compare values, buffered in PWM modes
    // ------------------------------------------------------------------

    // Single slope reloads at bottom, dual slope at top
    assign reload = pwm & cnt.tick & (fast ? cnt.at_bottom : cnt.at_top); // R7

    // Outside PWM a write lands in the active register at once
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            for (int ch = 0; ch < toc_pkg::NCH; ch++) begin
                cmp_act_q[ch] <= toc_pkg::CMP_RST;
                cmp_buf_q[ch] <= toc_pkg::CMP_RST;
            end
        end else begin
            for (int ch = 0; ch < toc_pkg::NCH; ch++) begin
                if (reload) begin
                    cmp_act_q[ch] <= cmp_buf_q[ch]; // R6 R7
                end
            end
            if (wr && paddr == toc_pkg::OFF_CMP_A) begin
                cmp_buf_q[0] <= pwdata[7:0]; // R8
                if (!pwm) begin
                    cmp_act_q[0] <= pwdata[7:0]; // R6 R8
                end
            end
            if (wr && paddr == toc_pkg::OFF_CMP_B) begin
                cmp_buf_q[1] <= pwdata[7:0]; // R8
                if (!pwm) begin
                    cmp_act_q[1] <= pwdata[7:0]; // R6 R8
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Match flags
    // ------------------------------------------------------------------

    // Set wins over a software clear or a service in the same cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            match_flag_q <= '0;
        end else begin
            for (int ch = 0; ch < toc_pkg::NCH; ch++) begin
                if (hit[ch]) begin
                    match_flag_q[ch] <= 1'b1; // R2
                end else if (wr && paddr == toc_pkg::OFF_FLAGS
                             && pwdata[ch]) begin
                    match_flag_q[ch] <= 1'b0; // R4
                end else if (irq_ack[ch] && irq_req[ch]) begin
                    match_flag_q[ch] <= 1'b0; // R3
                end
            end
        end
    end

    // Request follows the flag while enabled
    assign irq_req = match_flag_q & ctrl_q.int_en; // R3

    // ------------------------------------------------------------------
    // Waveform generator
    // ------------------------------------------------------------------

    // A forced match never reaches the flags, only the output
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_q <= '0;
        end else begin
            for (int ch = 0; ch < toc_pkg::NCH; ch++) begin
                if (!pwm) begin
                    if (hit[ch] || force_ev[ch]) begin // R10 R14
                        case (act[ch])
                            toc_pkg::ACT_TOGGLE: out_q[ch] <= ~out_q[ch]; // R21
                            toc_pkg::ACT_CLEAR:  out_q[ch] <= 1'b0; // R21
                            toc_pkg::ACT_SET:    out_q[ch] <= 1'b1; // R21
                            default:             out_q[ch] <= out_q[ch]; // R17
                        endcase
                    end
                end else if (fast) begin
                    // Wrap to bottom wins, so compare at max gives a flat level
                    if (cnt.tick && cnt.at_top && act[ch][1]) begin
                        out_q[ch] <= ~act[ch][0]; // R5 R22
                    end else if (hit[ch]) begin
                        case (act[ch])
                            toc_pkg::ACT_TOGGLE: out_q[ch] <= ~out_q[ch];
                            toc_pkg::ACT_CLEAR:  out_q[ch] <= 1'b0; // R22
                            toc_pkg::ACT_SET:    out_q[ch] <= 1'b1; // R22
                            default:             out_q[ch] <= out_q[ch]; // R17
                        endcase
                    end
                end else begin
                    // Compare at max holds the down-count level at top
                    if (cnt.tick && cnt.at_top && act[ch][1]
                        && cmp_act_q[ch] == toc_pkg::CNT_MAX) begin
                        out_q[ch] <= ~act[ch][0]; // R5
                    end else if (hit[ch]) begin
                        case (act[ch])
                            toc_pkg::ACT_TOGGLE: out_q[ch] <= ~out_q[ch];
                            toc_pkg::ACT_CLEAR,
                            toc_pkg::ACT_SET: begin
                                out_q[ch] <= cnt.down ? ~act[ch][0]
                                                      : act[ch][0]; // R23
                            end
                            default:             out_q[ch] <= out_q[ch]; // R17
                        endcase
                    end
                end
            end
        end
    end

    assign channel_output_state = out_q; // R12

    // ------------------------------------------------------------------
    // Port pin override
    // ------------------------------------------------------------------

    // Override is mode independent; direction stays with the port
    always_comb begin
        for (int ch = 0; ch < toc_pkg::NCH; ch++) begin
            connected[ch] = (act[ch] != toc_pkg::ACT_NONE);
            pin_out[ch]   = connected[ch] ? out_q[ch]
                                          : port_out_value[ch]; // R15
            pin_oe_n[ch]  = ~output_pin_direction_bit[ch]; // R16
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Read mux; force strobes always read back as zero
    always_comb begin
        rd_d = toc_pkg::RD_ZERO;
        case (paddr)
            toc_pkg::OFF_CTRL: begin
                rd_d[toc_pkg::CTRL_ACT_A_LSB +: 2] = ctrl_q.act_a;
                rd_d[toc_pkg::CTRL_ACT_B_LSB +: 2] = ctrl_q.act_b;
                rd_d[toc_pkg::CTRL_MODE_LSB +: 3]  = ctrl_q.mode;
                rd_d[toc_pkg::CTRL_IEN_LSB +: 2]   = ctrl_q.int_en;
            end
            toc_pkg::OFF_CMP_A: begin
                rd_d[7:0] = pwm ? cmp_buf_q[0] : cmp_act_q[0]; // R8
            end
            toc_pkg::OFF_CMP_B: begin
                rd_d[7:0] = pwm ? cmp_buf_q[1] : cmp_act_q[1]; // R8
            end
            toc_pkg::OFF_FLAGS: begin
                rd_d[1:0] = match_flag_q;
            end
            toc_pkg::OFF_STATUS: begin
                rd_d[toc_pkg::STAT_OUT_LSB +: 2]   = out_q;
                rd_d[toc_pkg::STAT_CMP_A_LSB +: 8] = cmp_act_q[0];
                rd_d[toc_pkg::STAT_CMP_B_LSB +: 8] = cmp_act_q[1];
            end
            default: begin
                rd_d = toc_pkg::RD_ZERO; // R24
            end
        endcase
    end

    // Captured in the setup cycle so prdata is a flop
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            prdata <= toc_pkg::RD_ZERO;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_d;
        end
    end

endmodule

// *** dv/toc_compare_asserts.sv ***
// Port-level checks for the two-channel output-compare block.
// Assumes it is bound into toc_compare and shares clk_sys and rst.
`timescale 1ns/10ps
module toc_compare_asserts (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              rst,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Counter, interrupts, pins
    input wire toc_pkg::toc_cnt_s cnt,
    input wire logic [1:0]        irq_req,
    input wire logic [1:0]        irq_ack,
    input wire logic [1:0]        port_out_value,
    input wire logic [1:0]        output_pin_direction_bit,
    input wire logic [1:0]        pin_out,
    input wire logic [1:0]        pin_oe_n,
    input wire logic [1:0]        channel_output_state
);
    // --------
    // Shadow of the control word
    // --------
    logic [9:0] ctl_q;
    logic       wr_acc;
    logic [1:0] pin_exp;
    logic       frc;
    assign wr_acc = psel && penable && pwrite;
    assign frc = wr_acc && paddr == toc_pkg::OFF_FORCE;
    assign pin_exp[0] = (ctl_q[1:0] != 2'h0) ? channel_output_state[0] : port_out_value[0];
    assign pin_exp[1] = (ctl_q[3:2] != 2'h0) ? channel_output_state[1] : port_out_value[1];
    // Taken at the same access edge as the block, so both use one word
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctl_q <= 10'h000;
        end else if (wr_acc && paddr == toc_pkg::OFF_CTRL) begin
            ctl_q <= pwdata[9:0];
        end
    end

    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // --------
    // Assertions
    // --------
    pin_dir_a: assert property (pin_oe_n == ~output_pin_direction_bit)
        else $error("pin enable not the inverse of direction");
    pin_source_a: assert property (pin_out == pin_exp)
        else $error("pin value from wrong source");
    action_none_a: assert property (ctl_q[1:0] == 2'h0 |=> $stable(channel_output_state[0]))
        else $error("output state moved with no action");
    force_level_a: assert property (frc && pwdata[0] && !ctl_q[4] && ctl_q[1] |=>
        channel_output_state[0] == $past(ctl_q[0]))
        else $error("forced match did not apply action");
    force_pwm_a: assert property (frc && ctl_q[4] && !cnt.tick |=>
        $stable(channel_output_state))
        else $error("force acted in a pwm mode");
    irq_service_a: assert property (irq_req[0] && irq_ack[0] && !cnt.tick |=> !irq_req[0])
        else $error("service did not clear request");
    irq_tick_a: assert property ($rose(irq_req[0]) && !$past(wr_acc) |-> $past(cnt.tick))
        else $error("request rose without a tick");
    write_block_a: assert property (cnt.count_write ##1
        (cnt.tick && !cnt.at_top && !cnt.at_bottom && !psel) |=>
        $stable(channel_output_state) && !$rose(irq_req[0]) && !$rose(irq_req[1]))
        else $error("match not blocked after counter write");
    state_cause_a: assert property (!$stable(channel_output_state) |->
        $past(cnt.tick) || $past(wr_acc) || $past(rst))
        else $error("output state moved off tick and write");

    cover property (irq_req[0] && irq_ack[0]);
    cover property (frc && ctl_q[4]);
    cover property (cnt.count_write ##1 cnt.tick);
endmodule

bind toc_compare toc_compare_asserts u_chk (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cnt(cnt), .irq_req(irq_req), .irq_ack(irq_ack), .port_out_value(port_out_value),
    .output_pin_direction_bit(output_pin_direction_bit), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .channel_output_state(channel_output_state)
);

// *** dv/toc_cnt_model.sv ***
// Counter model feeding the compare block: count, tick and write pulse.
// Assumes the bench asks for each tick and each counter write.
`timescale 1ns/10ps
module toc_cnt_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Requests from the bench
    input  wire logic        step,
    input  wire logic        load,
    input  wire logic [7:0]  load_val,
    // Indications to the block
    output toc_pkg::toc_cnt_s cnt
);
    logic [7:0] count_q;
    // Count moves on a tick or a write; a write wins over a tick
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_q <= toc_pkg::CNT_BOTTOM;
        end else if (load) begin
            count_q <= load_val;
        end else if (step) begin
            count_q <= count_q + 8'h01;
        end
    end
    // Single slope only: dual slope is not modelled
    assign cnt = '{count: count_q, down: 1'b0, at_top: count_q == toc_pkg::CNT_MAX,
                   at_bottom: count_q == toc_pkg::CNT_BOTTOM, tick: step,
                   count_write: load};
endmodule

// *** dv/tb_top.sv ***
// Self-checking bench for the output-compare block.
// Assumes the counter model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module tb_top;
    logic              clk_sys, rst, psel, penable, pwrite, step, load, pready, pslverr, err;
    logic [7:0]        paddr, lv, ca, cb, nb;
    logic [31:0]       pwdata, prdata, rd;
    logic [1:0]        irq_ack, pov, dir, irq_req, pin_out, pin_oe_n, cos, st;
    toc_pkg::toc_cnt_s cnt;
    int                n_mismatch, n_checks;

    toc_cnt_model u_cnt (.clk_sys(clk_sys), .rst(rst), .step(step), .load(load),
                         .load_val(lv), .cnt(cnt));
    toc_compare dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cnt(cnt), .irq_req(irq_req),
        .irq_ack(irq_ack), .port_out_value(pov), .output_pin_direction_bit(dir),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .channel_output_state(cos));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // --------
    // Tasks
    // --------
    task automatic stop_test();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            stop_test();
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, e);
    endtask
    // One counter write or one tick
    task automatic tick(input logic ld, input logic [7:0] v);
        @(posedge clk_sys);
        load <= ld;
        step <= ~ld;
        lv <= v;
        @(posedge clk_sys);
        load <= 1'b0;
        step <= 1'b0;
    endtask
    // Fresh random port value and direction, then compare the pins
    task automatic chk_pins(input logic [3:0] act);
        logic [1:0] ep;
        @(posedge clk_sys);
        pov <= 2'($urandom);
        dir <= 2'($urandom);
        #1;
        ep[0] = (act[1:0] != 2'h0) ? st[0] : pov[0];
        ep[1] = (act[3:2] != 2'h0) ? st[1] : pov[1];
        chk({30'h0, pin_out}, {30'h0, ep});
        chk({30'h0, pin_oe_n}, {30'h0, ~dir});
    endtask
    function automatic logic nxt(input logic [1:0] a, input logic s);
        return (a == 2'h1) ? ~s : (a == 2'h0) ? s : a[0];
    endfunction
    function automatic logic [31:0] stat();
        return {8'h00, cb, ca, 6'h00, st};
    endfunction

    // --------
    // Main sequence
    // --------
    initial begin
        {rst, psel, penable, pwrite, step, load} = 6'h20;
        {paddr, lv, pwdata, irq_ack, pov, dir} = '0;
        {n_mismatch, n_checks} = '0;
        void'($urandom(32'hb226_7277));
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rchk(8'(4 * i), 32'h0000_0000);
        apb(1'b0, 8'h18, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        ca = 8'($urandom_range(250, 2));
        cb = ca + 8'h01;
        st = 2'h0;
        apb(1'b1, toc_pkg::OFF_CMP_A, {24'h00_0000, ca});
        apb(1'b1, toc_pkg::OFF_CMP_B, {24'h00_0000, cb});
        rchk(toc_pkg::OFF_STATUS, stat());
        for (int a = 1; a < 4; a++) begin
            apb(1'b1, toc_pkg::OFF_CTRL, 32'(a));
            tick(1'b1, ca - 8'h01);
            tick(1'b0, 8'h00);
            tick(1'b0, 8'h00);
            st[0] = nxt(2'(a), st[0]);
            rchk(toc_pkg::OFF_FLAGS, 32'h0000_0001);
            chk_pins(4'(a));
            tick(1'b0, 8'h00);
            rchk(toc_pkg::OFF_STATUS, stat());
            apb(1'b1, toc_pkg::OFF_FLAGS, 32'h0000_0000);
            rchk(toc_pkg::OFF_FLAGS, 32'h0000_0003);
            apb(1'b1, toc_pkg::OFF_FLAGS, 32'h0000_0001);
            rchk(toc_pkg::OFF_FLAGS, 32'h0000_0002);
            apb(1'b1, toc_pkg::OFF_FORCE, 32'h0000_0001);
            st[0] = nxt(2'(a), st[0]);
            rchk(toc_pkg::OFF_STATUS, stat());
            rchk(toc_pkg::OFF_FLAGS, 32'h0000_0002);
            apb(1'b1, toc_pkg::OFF_FLAGS, 32'h0000_0002);
        end
        // Counter write, then a tick in the very next cycle: that tick is blocked
        @(posedge clk_sys);
        load <= 1'b1;
        lv <= ca;
        @(posedge clk_sys);
        load <= 1'b0;
        step <= 1'b1;
        @(posedge clk_sys);
        step <= 1'b0;
        rchk(toc_pkg::OFF_FLAGS, 32'h0000_0000);
        apb(1'b1, toc_pkg::OFF_CTRL, 32'h0000_0102);
        tick(1'b1, ca - 8'h01);
        tick(1'b0, 8'h00);
        tick(1'b0, 8'h00);
        st[0] = 1'b0;
        #1;
        chk({30'h0, irq_req}, 32'h0000_0001);
        @(posedge clk_sys);
        irq_ack <= 2'h1;
        @(posedge clk_sys);
        irq_ack <= 2'h0;
        #1;
        chk({30'h0, irq_req}, 32'h0000_0000);
        rchk(toc_pkg::OFF_FLAGS, 32'h0000_0000);
        apb(1'b1, toc_pkg::OFF_CTRL, 32'h0000_0031);
        apb(1'b1, toc_pkg::OFF_FORCE, 32'h0000_0001);
        rchk(toc_pkg::OFF_STATUS, stat());
        rchk(toc_pkg::OFF_FORCE, 32'h0000_0000);
        nb = ca - 8'h01;
        apb(1'b1, toc_pkg::OFF_CTRL, 32'h0000_0032);
        apb(1'b1, toc_pkg::OFF_CMP_A, {24'h00_0000, nb});
        rchk(toc_pkg::OFF_CMP_A, {24'h00_0000, nb});
        tick(1'b1, 8'hFE);
        tick(1'b0, 8'h00);
        tick(1'b0, 8'h00);
        st[0] = 1'b1;
        rchk(toc_pkg::OFF_STATUS, stat());
        tick(1'b0, 8'h00);
        ca = nb;
        rchk(toc_pkg::OFF_STATUS, stat());
        // Phase correct, counting up: action 2 clears, action 3 sets on a match
        for (int p = 2; p < 4; p++) begin
            apb(1'b1, toc_pkg::OFF_CTRL, 32'h0000_0010 + 32'(p));
            tick(1'b1, ca - 8'h01);
            tick(1'b0, 8'h00);
            tick(1'b0, 8'h00);
            st[0] = (p == 3);
            rchk(toc_pkg::OFF_STATUS, stat());
        end
        apb(1'b1, toc_pkg::OFF_CTRL, 32'h0000_0000);
        rchk(toc_pkg::OFF_STATUS, stat());
        chk_pins(4'h0);
        stop_test();
    end
endmodule
